// ---- dv/nfecc_flash_model.sv ----
// behavioural byte-wide nand flash device seen from the controller pins
`timescale 1ns/1ps
`default_nettype none
module nfecc_flash_model #(
    parameter int unsigned BUSY_CYC = 20   // busy time after an address byte
) (
    input  wire logic       i_clk,         // local clock
    input  wire logic       i_rstn,        // sync reset, active low
    input  wire logic [3:0] i_ce_n,        // chip enables, active low
    input  wire logic       i_ale,         // address latch
    input  wire logic       i_we_n,        // write strobe, active low
    input  wire logic       i_re_n,        // read strobe, active low
    output logic [7:0]      o_io,          // data toward the controller
    output logic            o_ready        // ready/busy, high ready
);
    // ------------------------------------------------------------------
    // page data and ready/busy
    // ------------------------------------------------------------------
    logic [7:0] cnt_r;                     // bytes read so far
    logic [7:0] last_r;                    // last byte put on the bus
    int         busy_r;                    // busy cycles left
    wire        rd_sel = !i_re_n && !(&i_ce_n);  // selected and strobed
    // released bus shows the inverse of the last byte, never a stale copy
    assign o_io = rd_sel ? (cnt_r * 8'h25 + 8'h6B) : ~last_r;
    assign o_ready = (busy_r == 0);
    // counters for reads and busy time
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_r  <= 8'h00;
            last_r <= 8'h00;
            busy_r <= 0;
        end else begin
            if (rd_sel) begin
                cnt_r  <= cnt_r + 8'h01;
                last_r <= o_io;
            end
            // busy starts on an address byte
            if (!i_we_n && i_ale) busy_r <= int'(BUSY_CYC);
            else if (busy_r != 0) busy_r <= busy_r - 1;
        end
    end
endmodule : nfecc_flash_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the nand flash ecc controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] BASE = 32'h4000_0000;      // window base
    logic        clock = 1'b0, rstn, req, wr, dword, rready;  // bench-driven controls
    logic [31:0] addr;                                 // request address
    logic [7:0]  wdata;                                // write byte
    logic [1:0]  lane;                                 // chip select lane
    logic        req_rdy, rvalid, hit, cle, ale, we_n, re_n, oe_n, irq, ready;
    logic [31:0] rdata;                                // read data
    logic [3:0]  ce_n;                                 // chip enables
    logic [7:0]  io_o, io_i;                           // flash bus both ways
    int          bad_count = 0, num_checks = 0;        // tallies
    logic [7:0]  nrd = 8'h00, la;                      // flash read index, line
    logic [21:0] acc;                                  // expected raw parity
    logic [10:0] welog [$];                            // {oe_n,cle,ale,io} per strobe
    logic [31:0] hit_ofs [4] = '{32'h0, 32'hFFF, 32'h1000, 32'hFFFF_FFFF};  // window probes
    logic [7:0]  wr_pat [4] = '{8'h80, 8'h01, 8'hFF, 8'h3C};   // data bytes written
    // base fixed before the first access
    nfecc_top #(.N_CS(4)) dut (
        .I_CLOCK(clock), .I_RSTN(rstn), .I_BASE(BASE), .I_LANE(lane), .I_REQ(req),
        .O_REQ_READY(req_rdy), .I_WR(wr), .I_ADDR(addr), .I_DWORD(dword),
        .I_WDATA(wdata), .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata),
        .O_HIT(hit), .O_CE_N(ce_n), .O_CLE(cle), .O_ALE(ale), .O_WE_N(we_n),
        .O_RE_N(re_n), .O_IO(io_o), .O_IO_OE_N(oe_n), .I_IO(io_i), .I_READY(ready),
        .O_IRQ(irq));
    nfecc_flash_model #(.BUSY_CYC(20)) flash (
        .i_clk(clock), .i_rstn(rstn), .i_ce_n(ce_n), .i_ale(ale), .i_we_n(we_n),
        .i_re_n(re_n), .o_io(io_i), .o_ready(ready));
    // ------------------------------------------------------------------
    // clock, strobe monitor and bus tasks
    // ------------------------------------------------------------------
    always #12.5 clock = ~clock;
    // record every write strobe with its latch state
    always @(negedge clock) if (we_n === 1'b0) welog.push_back({oe_n, cle, ale, io_o});
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one request, held until the edge that takes it
    task automatic issue(input logic w, input logic [11:0] ofs, input logic dw,
                         input logic [7:0] d);
        int n;
        @(negedge clock);
        {req, wr, addr, dword, wdata} = {1'b1, w, BASE + {20'h0, ofs}, dw, d};
        for (n = 0; n < 50 && req_rdy !== 1'b1; n++) @(negedge clock);
        if (req_rdy !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        @(posedge clock);
    endtask : issue
    task automatic idle;
        @(negedge clock);
        req = 1'b0;
    endtask : idle
    // release the request, wait for read data and take it
    task automatic pop(input logic [31:0] exp);
        int n;
        idle();
        for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(negedge clock);
        if (rvalid !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        chk(rdata, exp);
        rready = 1'b1;
        @(negedge clock);
        rready = 1'b0;
    endtask : pop
    task automatic wrb(input logic [11:0] ofs, input logic [7:0] d);
        issue(1'b1, ofs, 1'b0, d);
        idle();
    endtask : wrb
    task automatic fold(input logic [7:0] b);
        for (int c = 0; c < 8; c++) begin
            if (b[c]) begin
                for (int k = 0; k < 3; k++) acc[2*k + c[k]] ^= 1'b1;
                for (int k = 0; k < 8; k++) acc[6 + 2*k + la[k]] ^= 1'b1;
            end
        end
        la++;
    endtask : fold
    // page read of one flash byte, folded in when it is a data-area byte read, not a doubleword
    task automatic rpage(input logic [11:0] ofs, input logic dw);
        logic [7:0] b;
        b = nrd * 8'h25 + 8'h6B;
        nrd++;
        issue(1'b0, ofs, dw, 8'h00);
        pop({24'h0, b});
        if (!dw && ofs <= 12'h1FF) fold(b);
    endtask : rpage
    task automatic rreg(input logic [11:0] ofs, input logic [31:0] exp);
        issue(1'b0, ofs, 1'b1, 8'h00);
        pop(exp);
    endtask : rreg
    task automatic eccstart(input logic [7:0] d);
        wrb(12'h815, d);
        acc = '0;
        la = 8'h00;
    endtask : eccstart
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rstn, req, wr, dword, rready, addr, wdata, lane} = {5'b0, BASE, 8'h00, 2'd2};
        repeat (5) @(negedge clock);
        chk({ce_n, cle, ale, we_n, re_n, oe_n, irq, rvalid}, {4'hF, 7'b0011100});
        rstn = 1'b1;
        foreach (hit_ofs[i]) begin
            addr = BASE + hit_ofs[i];
            #2 chk(hit, (i < 2));
            @(negedge clock);
        end
        wrb(12'h800, 8'h02);
        chk({ce_n, cle, ale}, {4'hB, 2'b10});
        wrb(12'h801, 8'h00);
        wrb(12'h800, 8'h04);
        chk({ce_n, cle, ale}, {4'hB, 2'b01});
        issue(1'b1, 12'h801, 1'b0, 8'h12);
        wrb(12'h802, 8'h34);
        wrb(12'h800, 8'h08);
        chk({ce_n, cle, ale, irq}, {4'hB, 3'b000});
        chk(welog.size(), 32'd3);
        chk({welog[0], welog[1]}, {11'h200, 11'h112});
        chk(welog[2], 11'h134);
        for (int n = 0; n < 100 && irq !== 1'b1; n++) @(negedge clock);
        chk({irq, ready}, 2'b11);
        if (irq !== 1'b1) end_sim();
        wrb(12'h800, 8'h10);
        chk({ce_n, cle, ale, irq}, {4'hB, 3'b000});
        eccstart(8'h03);
        rreg(12'h815, 32'h1);
        for (int i = 0; i < 256; i++) rpage(i[11:0], 1'b0);
        rpage(12'h010, 1'b1);
        rreg(12'h810, {10'h0, ~acc});
        eccstart(8'h07);
        rreg(12'h815, 32'h5);
        for (int i = 256; i < 526; i++) rpage(i[11:0], 1'b0);
        issue(1'b0, 12'h20E, 1'b0, 8'h00);
        issue(1'b0, 12'h20F, 1'b0, 8'h00);
        idle();
        chk({req_rdy, rvalid}, 2'b01);
        repeat (3) @(negedge clock);
        pop({24'h0, nrd * 8'h25 + 8'h6B});
        pop({24'h0, (nrd + 8'h01) * 8'h25 + 8'h6B});
        nrd += 8'h02;
        rreg(12'h810, {10'h0, acc});
        eccstart(8'h03);
        foreach (wr_pat[i]) begin
            wrb(i[11:0], wr_pat[i]);
            fold(wr_pat[i]);
        end
        rreg(12'h810, {10'h0, ~acc});
        rreg(12'h900, 32'h0);
        lane = 2'h1;
        wrb(12'h800, 8'h02);
        chk({ce_n, cle, ale}, {4'hD, 2'b10});
        wrb(12'h800, 8'h01);
        chk({ce_n, cle, ale}, {4'hF, 2'b00});
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ---- pkg/nfecc_pkg.sv ----
// package of offsets, fields and codes for the nand flash ecc controller
`default_nettype none
package nfecc_pkg;
    // ------------------------------------------------------------------
    // window layout
    // ------------------------------------------------------------------
    localparam int unsigned WINDOW_BYTES   = 4096;      // decoded window size
    localparam logic [11:0] DATA_LAST      = 12'h20F;   // last page byte offset (527)
    localparam logic [11:0] DATA_AREA_LAST = 12'h1FF;   // last data-area byte (511)
    localparam logic [11:0] PIN_CTRL_OFS   = 12'h800;   // nand_pin_control
    localparam logic [11:0] PIN_CTRL_END   = 12'h80F;   // end of command/address region
    localparam logic [11:0] PARITY_OFS     = 12'h810;   // ecc_parity_result
    localparam logic [11:0] ECC_CTRL_OFS   = 12'h815;   // ecc_control
    // ------------------------------------------------------------------
    // control byte codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CTL_IDLE = 8'h01;   // release chip enable
    localparam logic [7:0] CTL_CMD  = 8'h02;   // chip enable and command latch
    localparam logic [7:0] CTL_ADDR = 8'h04;   // chip enable and address latch
    localparam logic [7:0] CTL_WAIT = 8'h08;   // chip enable, ready interrupt on
    localparam logic [7:0] ECC_START = 8'h03;  // clear parity, enable engine
    // ------------------------------------------------------------------
    // ecc control fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned ECC_EN_BIT    = 0;     // engine enable
    localparam int unsigned ECC_CLR_BIT   = 1;     // clear strobe
    localparam int unsigned ECC_EVEN_BIT  = 2;     // 1 = even presentation
    localparam logic        ECC_EVEN_RST  = 1'b0;  // odd after power-up
    localparam int unsigned PARITY_W      = 22;    // parity width
    localparam logic [7:0]  LINE_RST      = 8'h00; // line counter start
    // ------------------------------------------------------------------
    // pin phase encoding
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        NFECC_IDLE = 4'h1,
        NFECC_CMD  = 4'h2,
        NFECC_ADDR = 4'h4,
        NFECC_WAIT = 4'h8
    } nfecc_phase_t;
endpackage : nfecc_pkg
`default_nettype wire

// ---- rtl/nfecc_top.sv ----
// nand flash controller with 22-bit block ecc engine
`timescale 1ns/1ps
`default_nettype none
module nfecc_top #(
    parameter int unsigned N_CS = 4        // chip select lanes
) (
    input  wire logic        I_CLOCK,      // 40 MHz local clock
    input  wire logic        I_RSTN,       // sync reset, active low
    input  wire logic [31:0] I_BASE,       // programmed window base
    input  wire logic [1:0]  I_LANE,       // chip select lane to use
    input  wire logic        I_REQ,        // bus request valid
    output logic             O_REQ_READY,  // request accepted
    input  wire logic        I_WR,         // 1 = write
    input  wire logic [31:0] I_ADDR,       // byte address
    input  wire logic        I_DWORD,      // 1 = doubleword access
    input  wire logic [7:0]  I_WDATA,      // write byte
    output logic             O_RVALID,     // read data valid
    input  wire logic        I_RREADY,     // reader ready
    output logic [31:0]      O_RDATA,      // read data
    output logic             O_HIT,        // address inside window
    output logic [N_CS-1:0]  O_CE_N,       // chip enables, active low
    output logic             O_CLE,        // command latch
    output logic             O_ALE,        // address latch
    output logic             O_WE_N,       // write strobe, active low
    output logic             O_RE_N,       // read strobe, active low
    output logic [7:0]       O_IO,         // flash data out
    output logic             O_IO_OE_N,    // data out enable, low drives
    input  wire logic [7:0]  I_IO,         // flash data in
    input  wire logic        I_READY,      // flash ready/busy, high ready
    output logic             O_IRQ         // ready interrupt
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [31:0] ofs_full;                 // offset from base
    logic [11:0] ofs;                      // window offset
    logic        buf_full;                 // read buffer cannot accept
    logic        take;                     // request taken this cycle
    assign ofs_full    = I_ADDR - I_BASE;
    assign O_HIT       = ofs_full < nfecc_pkg::WINDOW_BYTES;
    assign ofs         = ofs_full[11:0];
    assign take        = I_REQ & O_REQ_READY & O_HIT;

    wire is_page   = ofs <= nfecc_pkg::DATA_LAST;
    wire is_data   = ofs <= nfecc_pkg::DATA_AREA_LAST;
    wire is_pin    = ofs == nfecc_pkg::PIN_CTRL_OFS;
    wire is_cmdreg = (ofs > nfecc_pkg::PIN_CTRL_OFS) && (ofs <= nfecc_pkg::PIN_CTRL_END);
    wire is_par    = ofs == nfecc_pkg::PARITY_OFS;
    wire is_ecc    = ofs == nfecc_pkg::ECC_CTRL_OFS;
    wire wr_pin    = take & I_WR & is_pin;
    wire wr_byte   = take & I_WR & is_cmdreg;
    wire wr_data   = take & I_WR & is_page;
    wire wr_ecc    = take & I_WR & is_ecc;
    wire rd_take   = take & ~I_WR;
    wire rd_page   = rd_take & is_page;
    // ------------------------------------------------------------------
    // pin phase
    // ------------------------------------------------------------------
    nfecc_pkg::nfecc_phase_t phase_r;      // current latch state
    nfecc_pkg::nfecc_phase_t phase_nxt;    // next latch state
    logic [7:0] pin_ctrl_r;                // last control byte
    logic       int_en_r;                  // ready interrupt enable
    logic [1:0] lane_r;                    // latched lane
    always_comb begin
        phase_nxt = phase_r;
        if (wr_pin) begin
            unique case (I_WDATA)
                nfecc_pkg::CTL_CMD:  phase_nxt = nfecc_pkg::NFECC_CMD;
                nfecc_pkg::CTL_ADDR: phase_nxt = nfecc_pkg::NFECC_ADDR;
                nfecc_pkg::CTL_WAIT: phase_nxt = nfecc_pkg::NFECC_WAIT;
                nfecc_pkg::CTL_IDLE: phase_nxt = nfecc_pkg::NFECC_IDLE;
                default:             phase_nxt = phase_r;
            endcase
        end
    end
    // phase register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RSTN) begin
            phase_r    <= nfecc_pkg::NFECC_IDLE;
            pin_ctrl_r <= nfecc_pkg::CTL_IDLE;
            int_en_r   <= 1'b0;
            lane_r     <= 2'h0;
        end else begin
            phase_r <= phase_nxt;
            if (wr_pin) begin
                pin_ctrl_r <= I_WDATA;
                int_en_r   <= (I_WDATA == nfecc_pkg::CTL_WAIT);
                lane_r     <= I_LANE;
            end
        end
    end
    wire ce_on = phase_r != nfecc_pkg::NFECC_IDLE;
    genvar g;
    generate
        for (g = 0; g < N_CS; g++) begin : g_ce
            assign O_CE_N[g] = ~(ce_on && (lane_r == 2'(g)));
        end
    endgenerate
    assign O_CLE = phase_r == nfecc_pkg::NFECC_CMD;
    assign O_ALE = phase_r == nfecc_pkg::NFECC_ADDR;
    // ------------------------------------------------------------------
    // strobes: one-cycle write pulse per byte, read strobe low in every page-read take cycle
    // ------------------------------------------------------------------
    logic       we_r;                      // write strobe pulse
    logic [7:0] io_r;                      // data driven
    // not ready in the cycle a write strobe is high so written bytes never share one pulse
    assign O_REQ_READY = ~buf_full & ~we_r;
    always_ff @(posedge I_CLOCK) begin
        if (!I_RSTN) begin
            we_r <= 1'b0;
            io_r <= 8'h00;
        end else begin
            we_r <= wr_byte | wr_data;
            if (wr_byte | wr_data)
                io_r <= I_WDATA;
        end
    end
    assign O_WE_N    = ~we_r;
    assign O_IO      = io_r;
    assign O_IO_OE_N = ~we_r;
    assign O_RE_N    = ~rd_page;
    // ------------------------------------------------------------------
    // ready interrupt
    // ------------------------------------------------------------------
    logic rdy_d_r;                         // last ready level
    logic irq_r;                           // interrupt flag
    always_ff @(posedge I_CLOCK) begin
        if (!I_RSTN) begin
            rdy_d_r <= 1'b1;
            irq_r   <= 1'b0;
        end else begin
            rdy_d_r <= I_READY;
            if (int_en_r && I_READY && !rdy_d_r)
                irq_r <= 1'b1;
            else if (wr_pin)
                irq_r <= 1'b0;
        end
    end
    assign O_IRQ = irq_r;
    // ------------------------------------------------------------------
    // ecc engine
    // ------------------------------------------------------------------
    logic                           ecc_en_r;   // engine running
    logic                           even_r;     // even presentation
    logic [7:0]                     line_r;     // line address counter
    logic [5:0]                     cpar_r;     // column parity bits
    logic [15:0]                    lpar_r;     // line parity bits
    logic [7:0]                     ecc_byte;   // byte moved
    logic [5:0]                     cfold;      // column terms of byte
    logic                           bpar;       // byte parity
    logic [15:0]                    lfold;      // line terms of byte
    logic [nfecc_pkg::PARITY_W-1:0] par_raw;    // engine parity
    logic [nfecc_pkg::PARITY_W-1:0] par_out;    // presented parity
    assign ecc_byte = I_WR ? I_WDATA : I_IO;
    wire ecc_hit = ecc_en_r & take & is_data & ~I_DWORD;
    assign bpar = ^ecc_byte;
    generate
        for (g = 0; g < 3; g++) begin : g_col
            logic [7:0] m1;
            for (genvar b = 0; b < 8; b++) begin : g_m
                assign m1[b] = ecc_byte[b] & 1'((b >> g) & 1);
            end
            assign cfold[2*g+1] = ^m1;
            assign cfold[2*g]   = bpar ^ (^m1);
        end
        for (g = 0; g < 8; g++) begin : g_line
            assign lfold[2*g+1] = bpar & line_r[g];
            assign lfold[2*g]   = bpar & ~line_r[g];
        end
    endgenerate
    always_ff @(posedge I_CLOCK) begin
        if (!I_RSTN) begin
            ecc_en_r <= 1'b0;
            even_r   <= nfecc_pkg::ECC_EVEN_RST;
            line_r   <= nfecc_pkg::LINE_RST;
            cpar_r   <= 6'h00;
            lpar_r   <= 16'h0000;
        end else if (wr_ecc) begin
            ecc_en_r <= I_WDATA[nfecc_pkg::ECC_EN_BIT];
            even_r   <= I_WDATA[nfecc_pkg::ECC_EVEN_BIT];
            if (I_WDATA[nfecc_pkg::ECC_CLR_BIT]) begin
                line_r <= nfecc_pkg::LINE_RST;
                cpar_r <= 6'h00;
                lpar_r <= 16'h0000;
            end
        end else if (ecc_hit) begin
            line_r <= line_r + 8'h01;
            cpar_r <= cpar_r ^ cfold;
            lpar_r <= lpar_r ^ lfold;
        end
    end
    assign par_raw = {lpar_r, cpar_r};
    assign par_out = even_r ? par_raw : ~par_raw;
    // ------------------------------------------------------------------
    // read data select and two-entry buffer
    // ------------------------------------------------------------------
    logic [31:0] rsel;                     // selected read word
    logic [31:0] q0_r;                     // head entry
    logic [31:0] q1_r;                     // second entry
    logic [1:0]  cnt_r;                    // entries held
    assign rsel = is_page ? {24'h000000, I_IO} :
                  is_par  ? {10'h000, par_out} :
                  is_pin  ? {24'h000000, pin_ctrl_r} :
                  is_ecc  ? {29'h0, even_r, 1'b0, ecc_en_r} : 32'h00000000;
    assign buf_full = cnt_r == 2'h2;
    wire pop  = O_RVALID & I_RREADY;
    // buffer control
    always_ff @(posedge I_CLOCK) begin
        if (!I_RSTN) begin
            cnt_r <= 2'h0;
            q0_r  <= 32'h00000000;
            q1_r  <= 32'h00000000;
        end else begin
            if (pop) begin
                q0_r <= (cnt_r == 2'h2) ? q1_r : rsel;
            end else if (rd_take && cnt_r == 2'h0) begin
                q0_r <= rsel;
            end
            if (rd_take && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2 && pop)))
                q1_r <= rsel;
            cnt_r <= cnt_r + {1'b0, rd_take} - {1'b0, pop};
        end
    end
    assign O_RVALID = cnt_r != 2'h0;
    assign O_RDATA  = q0_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_ecc_start;
        wr_ecc && I_WDATA == nfecc_pkg::ECC_START;
    endsequence
    AST_CMD_LATCH: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        wr_pin && I_WDATA == nfecc_pkg::CTL_CMD |=> O_CLE && !O_ALE)
        else $error("command code did not set command latch");
    AST_ADDR_LATCH: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        wr_pin && I_WDATA == nfecc_pkg::CTL_ADDR |=> O_ALE && !O_CLE && ~&O_CE_N)
        else $error("address code did not set address latch");
    AST_WAIT_CODE: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        wr_pin && I_WDATA == nfecc_pkg::CTL_WAIT |=> !O_ALE && int_en_r && ~&O_CE_N)
        else $error("wait code wrong");
    AST_IDLE_CODE: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        wr_pin && I_WDATA == nfecc_pkg::CTL_IDLE |=> &O_CE_N)
        else $error("idle code kept chip enable");
    AST_STROBE: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        wr_byte |=> !O_WE_N && O_IO == $past(I_WDATA) ##1 O_WE_N)
        else $error("byte strobe wrong");
    AST_IRQ: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        int_en_r && I_READY && !rdy_d_r |=> O_IRQ)
        else $error("ready did not interrupt");
    AST_CLEAR: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        s_ecc_start |=> par_raw == 22'h0 && line_r == 8'h00 && ecc_en_r)
        else $error("clear did not reset engine");
    AST_REDUNDANT: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        take && !is_data && !wr_ecc |=> $stable(par_raw))
        else $error("redundant byte changed parity");
    AST_LINE_STEP: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        ecc_hit && !wr_ecc |=> line_r == $past(line_r) + 8'h01)
        else $error("line counter did not step");
    AST_ODD_PRES: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        !even_r |-> par_out == ~par_raw)
        else $error("odd mode not inverted");
endmodule : nfecc_top
`default_nettype wire
